// File: verilog/bridge_adc_sync_acquisition.sv
// Bridge converter control, backplane lock and sample readout
//
// Function
// - Sync mode chosen in setup byte; period must be 200..2000 us.
// - Period multiplying the backplane cycle, or dividing it at most 4 times, locks conversions.
// - In sync mode, status bit 2 set while unlockable or settling, cleared when locked.
// - Lock tolerance 1 us below 1500 us period, 4 us above.
// - Wait 150 backplane cycles after enable or period change.
// - Period register used only in sync mode, aligning conversions.
// - Trim shifts converter clock 200 ppm per step, -50..50.
// - Out-of-range trim uses (serial mod 100 - 50) times -200 ppm.
// - Trim scales the conversion rate by the same proportion.
// - Sync mode ignores trim and slaves conversions to the cycle.
// - Trim register keeps only the low byte written.
// - Supply failure or unconfigured: status bit 0, raw 0xff800000.
// - Status bit 1 reports open bridge seen during the cycle.
// - 24-bit sample sign-extended; code 0x800000 becomes 0x800001, open bridge reads 0x7fffff.
// - Burst range bits 0..2 decoded, bits 3..7 forced zero.
// - Burst period code 0 is 50 us, 1 is 100 us, rest reserved.
// - Only the configured count, up to 10, of burst values sent.
// - Data-rate code 1110 selects synchronous mode.
// - Bus-controller model never locks, holds the period itself.
`timescale 1ns/1ns
module bridge_adc_sync_acquisition (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	input wire logic [7:0] func_model,
	input wire logic [6:0] serial_mod100,
	input wire logic cycle_pin,
	input wire logic bridge_fail_pin,
	input wire logic io_fail_pin,
	input wire logic conv_ready,
	input wire logic [23:0] conv_result,
	input wire logic conv_open,
	output logic conv_start,
	output logic [2:0] conv_range,
	output logic [15:0] conv_shift_ppm,
	input wire logic stream_ready,
	output logic stream_valid,
	output logic [31:0] stream_data
);
	typedef enum logic [2:0] {
		DIV_IDLE = 3'b001,
		DIV_RUN = 3'b010,
		DIV_DONE = 3'b100
	} div_state_t;

	function automatic logic [4:0] slot_of(input logic [15:0] a);
		logic [15:0] d;
		d = a - bridge_adc_pkg::SLOT_BASE;
		slot_of = 5'h0;
		if (d[1:0] == 2'h0 && d[15:2] >= 14'h1 && d[15:2] <= 14'ha)
			slot_of = {1'b1, 4'(d[15:2] - 14'h1)};
	endfunction : slot_of

	// ----------------------------------------------------------
	// Registers and pin synchronisers
	// ----------------------------------------------------------
	logic [7:0] setup_q, trim_q, range_q, bper_q;
	logic [15:0] period_q;
	logic [3:0] bcnt_q;
	logic cfg_done_q, restart_q;
	logic [2:0] p1_q, p2_q, p3_q, pin_q;
	logic [31:0] raw_q;
	logic [2:0] stat_q;
	logic [15:0] slot_q [0:9];
	logic [4:0] rslot;

	always_ff @(posedge mclk)
		if (rst) begin
			p1_q <= 3'h0;
			p2_q <= 3'h0;
			p3_q <= 3'h0;
			pin_q <= 3'h0;
		end else if (ce) begin
			p1_q <= {io_fail_pin, bridge_fail_pin, cycle_pin};
			p2_q <= p1_q;
			p3_q <= p2_q;
			pin_q <= (p2_q & p3_q) | (pin_q & (p2_q | p3_q));
		end

	logic ms, sync_sel, bc, cfg_ok, inval;
	assign ms = func_model == bridge_adc_pkg::FM_MULTI;
	assign bc = func_model == bridge_adc_pkg::FM_BC;
	assign sync_sel = !ms && setup_q[3:0] == bridge_adc_pkg::RATE_SYNC;
	assign cfg_ok = cfg_done_q &&
		(ms || setup_q[3:0] != bridge_adc_pkg::RATE_RSVD);
	assign inval = pin_q[1] || pin_q[2] || !cfg_ok;

	always_ff @(posedge mclk)
		if (rst) begin
			setup_q <= bridge_adc_pkg::SETUP_RST;
			period_q <= bridge_adc_pkg::PERIOD_RST;
			trim_q <= bridge_adc_pkg::TRIM_RST;
			range_q <= 8'h0;
			bper_q <= bridge_adc_pkg::BPER_RST;
			bcnt_q <= bridge_adc_pkg::BCNT_MAX;
			cfg_done_q <= 1'b0;
			restart_q <= 1'b0;
		end else if (ce) begin
			restart_q <= 1'b0;
			if (reg_wr)
				case (reg_addr)
					bridge_adc_pkg::REG_SETUP:
					begin
						setup_q <= {1'b0, reg_wdata[6:0]};
						cfg_done_q <= 1'b1;
						restart_q <= reg_wdata[3:0] != setup_q[3:0];
					end
					bridge_adc_pkg::REG_PERIOD:
					begin
						period_q <= reg_wdata[15:0];
						restart_q <= reg_wdata[15:0] != period_q;
					end
					bridge_adc_pkg::REG_TRIM: trim_q <= reg_wdata[7:0];
					bridge_adc_pkg::REG_RANGE:
						range_q <= {5'h0, reg_wdata[2:0]};
					bridge_adc_pkg::REG_BPER: bper_q <= reg_wdata[7:0];
					bridge_adc_pkg::REG_BCNT:
						bcnt_q <= (reg_wdata[31:0] > 32'ha) ?
							bridge_adc_pkg::BCNT_MAX : reg_wdata[3:0];
					default: ;
				endcase
		end

	assign rslot = slot_of(reg_addr);
	always_ff @(posedge mclk)
		if (rst) begin
			reg_rdata <= 32'h0;
			reg_ack <= 1'b0;
		end else if (ce) begin
			reg_ack <= reg_rd || reg_wr;
			if (reg_rd)
				case (reg_addr)
					bridge_adc_pkg::REG_STATUS: reg_rdata <= {29'h0, stat_q};
					bridge_adc_pkg::REG_RAW: reg_rdata <= raw_q;
					bridge_adc_pkg::REG_SETUP: reg_rdata <= {24'h0, setup_q};
					bridge_adc_pkg::REG_PERIOD: reg_rdata <= {16'h0, period_q};
					bridge_adc_pkg::REG_TRIM: reg_rdata <= {24'h0, trim_q};
					bridge_adc_pkg::REG_RANGE: reg_rdata <= {24'h0, range_q};
					bridge_adc_pkg::REG_BPER: reg_rdata <= {24'h0, bper_q};
					bridge_adc_pkg::REG_BCNT: reg_rdata <= {28'h0, bcnt_q};
					default: reg_rdata <= rslot[4] ?
						{{16{slot_q[rslot[3:0]][15]}}, slot_q[rslot[3:0]]} : 32'h0;
				endcase
		end

	// ----------------------------------------------------------
	// Backplane cycle measurement and lock test
	// ----------------------------------------------------------
	logic cyc_stb, pin0_d_q;
	logic [23:0] cyc_cnt_q, cyc_len_q, a_q, b_q, sel_ticks, tol;
	logic [15:0] sel_us, quo_q, ratio_q, ph_q;
	logic lockable_q, per_gt_q, settled, locked, aligned;
	logic [7:0] settle_q;
	div_state_t div_q;

	assign cyc_stb = pin_q[0] && !pin0_d_q;
	assign sel_us = ms ? (bper_q == 8'h0 ? bridge_adc_pkg::MS_P0_US :
		(bper_q == 8'h1 ? bridge_adc_pkg::MS_P1_US : 16'h0)) : period_q;
	assign sel_ticks = 24'(sel_us) * 24'(bridge_adc_pkg::TICKS_PER_US);
	assign tol = (ms || sel_us < bridge_adc_pkg::JIT_SPLIT_US) ?
		bridge_adc_pkg::JIT_SHORT_TICKS : bridge_adc_pkg::JIT_LONG_TICKS;

	always_ff @(posedge mclk)
		if (rst) begin
			pin0_d_q <= 1'b0;
			cyc_cnt_q <= 24'h0;
			cyc_len_q <= 24'h0;
		end else if (ce) begin
			pin0_d_q <= pin_q[0];
			cyc_cnt_q <= cyc_stb ? 24'h0 : cyc_cnt_q + 24'h1;
			if (cyc_stb)
				cyc_len_q <= cyc_cnt_q + 24'h1;
		end

	always_ff @(posedge mclk)
		if (rst) begin
			div_q <= DIV_IDLE;
			a_q <= 24'h0;
			b_q <= 24'h0;
			quo_q <= 16'h0;
			ratio_q <= 16'h0;
			per_gt_q <= 1'b0;
			lockable_q <= 1'b0;
		end else if (ce)
			case (div_q)
				DIV_IDLE:
					if (cyc_stb && cyc_len_q != 24'h0) begin
						per_gt_q <= sel_ticks > cyc_len_q;
						a_q <= sel_ticks > cyc_len_q ? sel_ticks : cyc_len_q;
						b_q <= sel_ticks > cyc_len_q ? cyc_len_q : sel_ticks;
						quo_q <= 16'h0;
						div_q <= DIV_RUN;
					end
				DIV_RUN:
					if (b_q != 24'h0 && a_q >= b_q) begin
						a_q <= a_q - b_q;
						quo_q <= quo_q + 16'h1;
					end else
						div_q <= DIV_DONE;
				DIV_DONE:
				begin
					// Divisor or multiple within jitter tolerance
					lockable_q <= b_q != 24'h0 && (a_q <= tol ||
						b_q - a_q <= tol) && (ms || (period_q >=
						bridge_adc_pkg::SYNC_MIN_US && period_q <=
						bridge_adc_pkg::SYNC_MAX_US && 26'(sel_ticks) * 26'h4 >=
						26'(cyc_len_q)));
					ratio_q <= (a_q <= tol) ? quo_q : quo_q + 16'h1;
					div_q <= DIV_IDLE;
				end
				default: div_q <= DIV_IDLE;
			endcase

	// Settling counts backplane cycles after a rate-code or period change, or entry to sync mode
	always_ff @(posedge mclk)
		if (rst)
			settle_q <= 8'h0;
		else if (ce) begin
			if (restart_q || !sync_sel)
				settle_q <= 8'h0;
			else if (cyc_stb && !settled)
				settle_q <= settle_q + 8'h1;
		end

	assign settled = settle_q == bridge_adc_pkg::SETTLE_CYC;
	assign locked = ms ? lockable_q :
		(sync_sel && !bc && lockable_q && settled);
	assign aligned = cyc_stb && locked && (!per_gt_q || ph_q == 16'h0);

	always_ff @(posedge mclk)
		if (rst)
			ph_q <= 16'h0;
		else if (ce && cyc_stb)
			ph_q <= (ph_q + 16'h1 >= ratio_q) ? 16'h0 : ph_q + 16'h1;

	// ----------------------------------------------------------
	// Conversion timing and clock trim
	// ----------------------------------------------------------
	logic signed [7:0] step;
	logic [31:0] base, len, tmr_q;
	logic signed [63:0] corr;

	always_comb begin
		if ($signed(trim_q) >= bridge_adc_pkg::TRIM_LO &&
			$signed(trim_q) <= bridge_adc_pkg::TRIM_HI)
			step = $signed(trim_q);
		else
			step = bridge_adc_pkg::SERIAL_MID -
				$signed({1'b0, serial_mod100});
	end

	assign base = bridge_adc_pkg::rate_ticks(setup_q[3:0]);
	assign corr = ($signed(64'(base)) * 64'(signed'(step)) *
		64'(bridge_adc_pkg::TRIM_RECIP)) >>> bridge_adc_pkg::TRIM_SHIFT;
	assign len = (ms || sync_sel) ? 32'(sel_ticks) :
		base - 32'(corr);

	always_ff @(posedge mclk)
		if (rst) begin
			tmr_q <= 32'h0;
			conv_start <= 1'b0;
			conv_range <= 3'h0;
			conv_shift_ppm <= 16'h0;
		end else if (ce) begin
			conv_range <= ms ? range_q[2:0] : setup_q[6:4];
			conv_shift_ppm <= (ms || sync_sel) ? 16'h0 :
				16'(signed'(step)) * 16'(bridge_adc_pkg::TRIM_STEP_PPM);
			if (!cfg_ok || len == 32'h0) begin
				tmr_q <= 32'h0;
				conv_start <= 1'b0;
			end else if (aligned) begin
				tmr_q <= 32'h0;
				conv_start <= tmr_q > 32'(tol);
			end else if (tmr_q >= len - 32'h1) begin
				tmr_q <= 32'h0;
				conv_start <= 1'b1;
			end else begin
				tmr_q <= tmr_q + 32'h1;
				conv_start <= 1'b0;
			end
		end

	// ----------------------------------------------------------
	// Samples, status and burst slots
	// ----------------------------------------------------------
	logic [23:0] val;
	logic [15:0] ring_q [0:15];
	logic [3:0] wp_q, ncnv_q;
	logic open_acc_q;

	assign val = conv_open ? bridge_adc_pkg::RAW_POS_FS :
		(conv_result == bridge_adc_pkg::RAW_NEG_INV ?
		bridge_adc_pkg::RAW_NEG_FS : conv_result);

	always_ff @(posedge mclk)
		if (rst) begin
			raw_q <= bridge_adc_pkg::RAW_INVALID;
			stat_q <= 3'h1;
			open_acc_q <= 1'b0;
			wp_q <= 4'h0;
			ncnv_q <= 4'h0;
		end else if (ce) begin
			stat_q[0] <= inval;
			stat_q[2] <= sync_sel && !locked;
			if (inval)
				raw_q <= bridge_adc_pkg::RAW_INVALID;
			else if (conv_ready)
				raw_q <= {{8{val[23]}}, val};
			if (cyc_stb) begin
				stat_q[1] <= open_acc_q || (conv_ready && conv_open);
				open_acc_q <= conv_ready && conv_open;
			end else if (conv_ready && conv_open)
				open_acc_q <= 1'b1;
			if (conv_ready) begin
				wp_q <= wp_q + 4'h1;
				ring_q[wp_q] <= val[23:8];
			end
			if (cyc_stb)
				ncnv_q <= 4'h0;
			else if (conv_ready && ncnv_q != 4'hf)
				ncnv_q <= ncnv_q + 4'h1;
		end

	// Slot n holds the n-th of the last bcnt values of the cycle
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_slot
			always_ff @(posedge mclk)
				if (rst)
					slot_q[gi] <= bridge_adc_pkg::SLOT_INVALID;
				else if (ce && cyc_stb)
					slot_q[gi] <= (!ms || !lockable_q || inval ||
						4'(gi) >= bcnt_q || bcnt_q - 4'(gi) > ncnv_q) ?
						bridge_adc_pkg::SLOT_INVALID :
						ring_q[wp_q - bcnt_q + 4'(gi)];
		end
	endgenerate

	// ----------------------------------------------------------
	// Output stream through a two-entry skid buffer
	// ----------------------------------------------------------
	logic pend_q, em_q, in_valid, in_ready, skid_v_q;
	logic [3:0] em_idx_q;
	logic [31:0] in_data, skid_q;

	assign in_ready = !skid_v_q;
	assign in_valid = em_q || pend_q;
	assign in_data = em_q ? {{16{slot_q[em_idx_q][15]}}, slot_q[em_idx_q]} :
		raw_q;

	always_ff @(posedge mclk)
		if (rst) begin
			pend_q <= 1'b0;
			em_q <= 1'b0;
			em_idx_q <= 4'h0;
		end else if (ce) begin
			if (cyc_stb && !em_q) begin
				em_q <= ms && bcnt_q != 4'h0;
				em_idx_q <= 4'h0;
			end else if (em_q && in_ready) begin
				em_idx_q <= em_idx_q + 4'h1;
				if (em_idx_q == bcnt_q - 4'h1)
					em_q <= 1'b0;
			end
			if (!ms && conv_ready)
				pend_q <= 1'b1;
			else if (!em_q && in_ready)
				pend_q <= 1'b0;
		end

	always_ff @(posedge mclk)
		if (rst) begin
			stream_valid <= 1'b0;
			stream_data <= 32'h0;
			skid_v_q <= 1'b0;
			skid_q <= 32'h0;
		end else if (ce) begin
			if (!stream_valid || stream_ready) begin
				if (skid_v_q) begin
					stream_data <= skid_q;
					stream_valid <= 1'b1;
					skid_v_q <= 1'b0;
				end else begin
					stream_data <= in_data;
					stream_valid <= in_valid;
				end
			end else if (in_valid && in_ready) begin
				skid_q <= in_data;
				skid_v_q <= 1'b1;
			end
		end
endmodule : bridge_adc_sync_acquisition

// File: verilog/bridge_adc_pkg.sv
// Constants for the bridge converter acquisition block
package bridge_adc_pkg;
	// Clock and timing
	localparam logic [7:0] TICKS_PER_US = 8'hfa;
	localparam logic [15:0] SYNC_MIN_US = 16'h00c8;
	localparam logic [15:0] SYNC_MAX_US = 16'h07d0;
	localparam logic [15:0] JIT_SPLIT_US = 16'h05dc;
	localparam logic [7:0] JIT_SHORT_US = 8'h01;
	localparam logic [7:0] JIT_LONG_US = 8'h04;
	localparam logic [23:0] JIT_SHORT_TICKS = JIT_SHORT_US * TICKS_PER_US;
	localparam logic [23:0] JIT_LONG_TICKS = JIT_LONG_US * TICKS_PER_US;
	localparam logic [15:0] MS_P0_US = 16'h0032;
	localparam logic [15:0] MS_P1_US = 16'h0064;
	localparam logic [7:0] SETTLE_CYC = 8'h96;
	localparam logic [31:0] CLK_HZ_X10 = 32'h9502f900;
	// Register numbers
	localparam logic [15:0] REG_STATUS = 16'h0002;
	localparam logic [15:0] REG_RAW = 16'h0004;
	localparam logic [15:0] REG_SETUP = 16'h0010;
	localparam logic [15:0] REG_PERIOD = 16'h0012;
	localparam logic [15:0] REG_TRIM = 16'h0020;
	localparam logic [15:0] REG_RANGE = 16'h0641;
	localparam logic [15:0] REG_BPER = 16'h0643;
	localparam logic [15:0] REG_BCNT = 16'h0645;
	localparam logic [15:0] SLOT_BASE = 16'h05fe;
	// Reset values
	localparam logic [7:0] SETUP_RST = 8'h0d;
	localparam logic [15:0] PERIOD_RST = 16'h0190;
	localparam logic [7:0] TRIM_RST = 8'h7f;
	localparam logic [7:0] BPER_RST = 8'h00;
	localparam logic [3:0] BCNT_MAX = 4'ha;
	// Field codes
	localparam logic [3:0] RATE_SYNC = 4'he;
	localparam logic [3:0] RATE_RSVD = 4'hf;
	localparam logic [7:0] FM_MULTI = 8'h01;
	localparam logic [7:0] FM_BC = 8'hfe;
	localparam logic [31:0] RAW_INVALID = 32'hff800000;
	localparam logic [15:0] SLOT_INVALID = 16'h8000;
	localparam logic [23:0] RAW_NEG_INV = 24'h800000;
	localparam logic [23:0] RAW_NEG_FS = 24'h800001;
	localparam logic [23:0] RAW_POS_FS = 24'h7fffff;
	// Trim: 200 ppm per step, step / 5000 = step * 13422 >> 26
	localparam logic signed [7:0] TRIM_LO = -8'sh32;
	localparam logic signed [7:0] TRIM_HI = 8'sh32;
	localparam logic signed [7:0] SERIAL_MID = 8'sh32;
	localparam logic [7:0] TRIM_STEP_PPM = 8'hc8;
	localparam logic [15:0] TRIM_RECIP = 16'h346e;
	localparam int TRIM_SHIFT = 26;

	function automatic logic [31:0] rate_ticks(input logic [3:0] code);
		case (code)
			4'h0: rate_ticks = CLK_HZ_X10 / 32'h19;
			4'h1: rate_ticks = CLK_HZ_X10 / 32'h32;
			4'h2: rate_ticks = CLK_HZ_X10 / 32'h64;
			4'h3: rate_ticks = CLK_HZ_X10 / 32'h96;
			4'h4: rate_ticks = CLK_HZ_X10 / 32'hfa;
			4'h5: rate_ticks = CLK_HZ_X10 / 32'h12c;
			4'h6: rate_ticks = CLK_HZ_X10 / 32'h1f4;
			4'h7: rate_ticks = CLK_HZ_X10 / 32'h258;
			4'h8: rate_ticks = CLK_HZ_X10 / 32'h3e8;
			4'h9: rate_ticks = CLK_HZ_X10 / 32'h1388;
			4'ha: rate_ticks = CLK_HZ_X10 / 32'h2710;
			4'hb: rate_ticks = CLK_HZ_X10 / 32'h4e20;
			4'hc: rate_ticks = CLK_HZ_X10 / 32'h927c;
			4'hd: rate_ticks = CLK_HZ_X10 / 32'h124f8;
			default: rate_ticks = 32'h0;
		endcase
	endfunction : rate_ticks
endpackage : bridge_adc_pkg

// File: verif/bridge_adc_asserts.sv
// Port-level checker for the bridge converter acquisition block
`timescale 1ns/1ns
module bridge_adc_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic [7:0] func_model,
	input wire logic bridge_fail_pin,
	input wire logic io_fail_pin,
	input wire logic conv_start,
	input wire logic [15:0] conv_shift_ppm,
	input wire logic stream_ready,
	input wire logic stream_valid,
	input wire logic [31:0] stream_data
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence fail_rd;
		(ce && (bridge_fail_pin || io_fail_pin))[*8] ##0
			(reg_rd && reg_addr == 16'h0002);
	endsequence
	a_ack_follows: assert property (ce && (reg_wr || reg_rd) |=> reg_ack)
		else $error("access not acknowledged");
	a_ack_lone: assert property (ce && !reg_wr && !reg_rd |=> !reg_ack)
		else $error("spurious acknowledge");
	a_stream_hold: assert property (ce && stream_valid && !stream_ready
		|=> stream_valid && $stable(stream_data))
		else $error("stream word dropped while stalled");
	a_start_pulse: assert property (ce && conv_start |=> !conv_start)
		else $error("start pulse too long");
	a_shift_multi: assert property ((ce && func_model == 8'h01)[*3]
		|=> conv_shift_ppm == 16'h0000)
		else $error("trim applied in multisample mode");
	a_status_rsvd: assert property (reg_rd && reg_addr == 16'h0002
		|=> reg_rdata[31:3] == 29'h0)
		else $error("reserved status bits set");
	a_range_rsvd: assert property (reg_rd && reg_addr == 16'h0641
		|=> reg_rdata[31:3] == 29'h0)
		else $error("reserved range bits set");
	a_period_word: assert property (reg_rd && reg_addr == 16'h0012
		|=> reg_rdata[31:16] == 16'h0)
		else $error("period wider than 16 bits");
	a_count_max: assert property (reg_rd && reg_addr == 16'h0645
		|=> reg_rdata <= 32'h0000000a)
		else $error("burst count above 10");
	a_fail_flag: assert property (fail_rd |=> reg_rdata[0])
		else $error("supply failure not flagged");
	c_stall: cover property (stream_valid && !stream_ready ##1 stream_ready);
	c_start: cover property (conv_start);
	c_unsync: cover property (reg_ack && reg_rdata[2]);
endmodule : bridge_adc_checker

// File: verif/backplane_ctrl_model.sv
// Backplane controller stand-in: cycle marker and stalling sample reader
`timescale 1ns/1ns
module backplane_ctrl_model #(
	parameter int CYC = 300
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hold,
	output logic cycle_pin,
	output logic stream_ready
);
	int cnt = 0;
	int seed = 93010;
	initial
	begin
		cycle_pin = 1'b0;
		stream_ready = 1'b0;
	end
	// Fixed cycle of CYC clocks, marker high for the first 20
	always @(posedge mclk)
	begin
		cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
		cycle_pin <= !rst && (cnt < 20);
		stream_ready <= !rst && !hold && ($random(seed) % 4 != 0);
	end
endmodule : backplane_ctrl_model

// File: verif/testbench.sv
// Self-checking bench for the bridge converter acquisition block
`timescale 1ns/1ns
module testbench;
	typedef struct packed {logic [31:0] e; logic [31:0] m;} note_t;
	localparam int CYC = 300;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_ack;
	logic [7:0] func_model = 8'h00;
	logic cycle_pin;
	logic bridge_fail_pin = 1'b0;
	logic io_fail_pin = 1'b0;
	logic conv_ready = 1'b0;
	logic [23:0] conv_result = 24'h0;
	logic conv_open = 1'b0;
	logic conv_start;
	logic [2:0] conv_range;
	logic [15:0] conv_shift_ppm;
	logic stream_ready;
	logic stream_valid;
	logic [31:0] stream_data;
	logic hold = 1'b0;
	logic ce = 1'b1;
	logic watch = 1'b1;
	logic seen = 1'b0;
	logic [23:0] r;
	int bad_count = 0;
	int checks_done = 0;
	int seed = 93010;
	int cycles = 0;
	note_t n;
	note_t rq[$];
	logic [31:0] sq[$];
	logic [15:0] ra [7] = '{16'h2, 16'h10, 16'h12, 16'h20, 16'h641, 16'h643, 16'h645};
	logic [31:0] rv [7] = '{32'h1, 32'hd, 32'h190, 32'h7f, 32'h0, 32'h0, 32'ha};
	logic [15:0] wa [7] = '{16'h10, 16'h12, 16'h20, 16'h641, 16'h643, 16'h645, 16'h3};
	logic [31:0] wd [7] = '{32'h8d, 32'h100c8, 32'h100, 32'hff, 32'h1, 32'hf, 32'hff};
	logic [31:0] we [7] = '{32'hd, 32'hc8, 32'h0, 32'h7, 32'h1, 32'ha, 32'h0};
	logic [31:0] tw [5] = '{32'h32, 32'hce, 32'h1, 32'h33, 32'h100};
	logic [15:0] te [5] = '{16'h2710, 16'hd8f0, 16'h00c8, 16'h0a28, 16'h0};
	always #2 mclk = ~mclk;
	bridge_adc_sync_acquisition i_bridge_adc_sync_acquisition (.mclk, .rst,
		.ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack,
		.func_model, .serial_mod100(7'h25), .cycle_pin, .bridge_fail_pin,
		.io_fail_pin, .conv_ready, .conv_result, .conv_open, .conv_start,
		.conv_range, .conv_shift_ppm, .stream_ready, .stream_valid, .stream_data);
	backplane_ctrl_model #(.CYC(CYC)) i_backplane_ctrl_model (.mclk, .rst,
		.hold, .cycle_pin, .stream_ready);
	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d, errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		@(posedge mclk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		rq.push_back({e, m});
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : acc
	task automatic smp(input logic [23:0] v, input logic op);
		@(posedge mclk);
		conv_ready <= 1'b1;
		conv_result <= v;
		conv_open <= op;
		sq.push_back(op ? 32'h007fffff : (v == 24'h800000) ? 32'hff800001 :
			{{8{v[23]}}, v});
		@(posedge mclk);
		conv_ready <= 1'b0;
	endtask : smp
	// ---------------------------------------------
	// Result monitor and hang guard
	// ---------------------------------------------
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		seen <= seen | (conv_start === 1'b1);
		if (reg_ack === 1'b1)
		begin
			n = rq.pop_front();
			check(((reg_rdata ^ n.e) & n.m) === 32'h0, "register value");
		end
		if (stream_valid === 1'b1 && stream_ready === 1'b1 && sq.size() > 0)
			check(stream_data === sq.pop_front(), "stream word");
		else if (stream_valid === 1'b1 && stream_ready === 1'b1 && watch)
			check(1'b0, "unexpected stream word");
		if (cycles == 95000)
		begin
			check(1'b0, "run timed out");
			tally_and_finish();
		end
	end
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		check(conv_shift_ppm === 16'h0a28, "serial trim");
		for (int i = 0; i < 7; i++)
			acc(1'b0, ra[i], 32'h0, rv[i], (i == 2) ? '1 : 32'hff);
		for (int i = 0; i < 7; i++)
		begin
			acc(1'b1, wa[i], wd[i], 32'h0, 32'h0);
			acc(1'b0, wa[i], 32'h0, we[i], '1);
		end
		for (int i = 0; i < 5; i++)
		begin
			acc(1'b1, 16'h20, tw[i], 32'h0, 32'h0);
			repeat (4) @(posedge mclk);
			check(conv_shift_ppm === te[i], "trim shift");
		end
		ce <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= 16'h20;
		reg_wdata <= 32'h5;
		repeat (3) @(posedge mclk);
		check(reg_ack === 1'b0, "bus answered while frozen");
		reg_wr <= 1'b0;
		ce <= 1'b1;
		acc(1'b0, 16'h20, 32'h0, 32'h0, '1);
		smp(24'h7fffff, 1'b1);
		repeat (CYC + 30) @(posedge mclk);
		acc(1'b0, 16'h2, 32'h0, 32'h2, 32'h7);
		for (int i = 0; i < 6; i++)
		begin
			r = 24'($random(seed));
			smp(r, 1'b0);
			repeat (8) @(posedge mclk);
		end
		smp(24'h800001, 1'b0);
		repeat (2 * CYC + 30) @(posedge mclk);
		acc(1'b0, 16'h2, 32'h0, 32'h0, 32'h7);
		acc(1'b0, 16'h4, 32'h0, 32'hff800001, '1);
		hold <= 1'b1;
		repeat (3) @(posedge mclk);
		smp(24'h123456, 1'b0);
		repeat (4) @(posedge mclk);
		smp(24'h800000, 1'b0);
		repeat (6) @(posedge mclk);
		check(stream_valid === 1'b1, "stalled word lost");
		hold <= 1'b0;
		repeat (20) @(posedge mclk);
		check(sq.size() == 0, "stream words missing");
		watch <= 1'b0;
		acc(1'b1, 16'h10, 32'h0e, 32'h0, 32'h0);
		acc(1'b0, 16'h2, 32'h0, 32'h4, 32'h5);
		func_model <= 8'hfe;
		repeat (3 * CYC) @(posedge mclk);
		acc(1'b0, 16'h2, 32'h0, 32'h4, 32'h5);
		func_model <= 8'h00;
		acc(1'b1, 16'h10, 32'h0f, 32'h0, 32'h0);
		acc(1'b0, 16'h2, 32'h0, 32'h1, 32'h5);
		acc(1'b1, 16'h10, 32'h0d, 32'h0, 32'h0);
		acc(1'b0, 16'h2, 32'h0, 32'h0, 32'h5);
		func_model <= 8'h01;
		repeat (2 * CYC) @(posedge mclk);
		check(conv_shift_ppm === 16'h0, "shift in multisample");
		check(conv_range === 3'h7, "burst range");
		func_model <= 8'h00;
		for (int p = 0; p < 2; p++)
		begin
			bridge_fail_pin <= (p == 0);
			io_fail_pin <= (p == 1);
			repeat (40) @(posedge mclk);
			acc(1'b0, 16'h2, 32'h0, 32'h1, 32'h1);
			acc(1'b0, 16'h4, 32'h0, 32'hff800000, '1);
			bridge_fail_pin <= 1'b0;
			io_fail_pin <= 1'b0;
			repeat (40) @(posedge mclk);
			acc(1'b0, 16'h2, 32'h0, 32'h0, 32'h1);
		end
		acc(1'b1, 16'h10, 32'h0e, 32'h0, 32'h0);
		repeat (152 * CYC) @(posedge mclk);
		acc(1'b0, 16'h2, 32'h0, 32'h0, 32'h4);
		acc(1'b1, 16'h10, 32'h0d, 32'h0, 32'h0);
		seen <= 1'b0;
		repeat (40000) @(posedge mclk);
		check(seen, "no conversion started");
		tally_and_finish();
	end
endmodule : testbench
bind bridge_adc_sync_acquisition bridge_adc_checker i_bridge_adc_checker (
	.mclk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .reg_ack,
	.func_model, .bridge_fail_pin, .io_fail_pin, .conv_start, .conv_shift_ppm,
	.stream_ready, .stream_valid, .stream_data);
